// ==== bench/spt_regs_assertions.sv ====
// concurrent checks on the synthesizer test register bank ports
`timescale 1ns/100ps
module spt_regs_chk
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire spt_pkg::spt_bus_t bus,
    input wire spt_pkg::spt_analog_in_t ana_in,
    input wire spt_pkg::spt_ctrl_t ctrl,
    input wire logic [spt_pkg::DATA_W-1:0] rd_data
);
    import spt_pkg::*;
    // ==========================================================
    // shadow of override fields, rebuilt from observed writes
    logic blk; // pulse block
    logic pfen; // pump force enable
    logic ofen; // array force enable
    logic opn; // loop open
    logic [4:0] pf; // forced pump value
    logic [3:0] of; // forced array value
    logic [3:0] dac; // forced dac value
    logic cal_wr; // write setting the start bit
    assign cal_wr = bus.wr && bus.addr == CAL_CTRL_OFS && bus.wdata[CAL_START_BIT];

    // shadow follows the same write edge as the bank itself
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            {pfen, pf} <= {1'b0, PUMP_FORCE_RST};
            {blk, ofen, of} <= {2'b00, OSC_FORCE_RST};
            {opn, dac} <= {1'b0, DAC_FORCE_RST};
        end
        else if (bus.wr && bus.addr == PROBE_PUMP_OFS)
            {pfen, pf} <= bus.wdata[5:0];
        else if (bus.wr && bus.addr == PUMP_BLOCK_OSC_OFS)
            {blk, ofen, of} <= bus.wdata[5:0];
        else if (bus.wr && bus.addr == LOOP_OPEN_DAC_OFS)
            {opn, dac} <= bus.wdata[4:0];
    end

    // ==========================================================
    // assertions; stability guards hide the one-cycle write skew
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    rd_idle_a:
        assert property (!$past(bus.rd) |-> rd_data == 8'h00) else $error("read data outside answer cycle");
    pump_force_a:
        assert property (!$past(rst) && $stable(pfen) && $stable(pf)
            |-> ctrl.pump_level == (pfen ? pf : $past(ana_in.pump_level))) else $error("pump level wrong");
    osc_force_a:
        assert property (!$past(rst) && $stable(ofen) && $stable(of)
            |-> ctrl.osc_array == (ofen ? of : $past(ana_in.osc_array))) else $error("osc array wrong");
    dac_force_a:
        assert property (!$past(rst) && $stable(opn) && $stable(dac)
            |-> ctrl.cal_dac == (opn ? dac : $past(ana_in.cal_dac))) else $error("cal dac wrong");
    loop_open_a:
        assert property (!$past(rst) |-> ctrl.loop_open == opn) else $error("loop open wrong");
    pulse_block_a:
        assert property (!$past(rst) && $stable(blk) |-> ctrl.pump_up == ($past(ana_in.up_req) && !blk)
            && ctrl.pump_dn == ($past(ana_in.dn_req) && !blk)) else $error("pump pulses wrong");
    probe_gnd_a:
        assert property (ctrl.probe_ground == !(ctrl.filter_probe_one || ctrl.filter_probe_two))
        else $error("probe ground wrong");
    cal_kick_a:
        assert property (ctrl.cal_begin |-> $past(cal_wr) ##1 !ctrl.cal_begin) else $error("cal kick wrong");
    pump_rb_a:
        assert property ($past(bus.rd) && $past(bus.addr) == PUMP_LEVEL_RB_OFS && $stable(ctrl.pump_level)
            |-> rd_data == {3'h0, ctrl.pump_level}) else $error("pump readback wrong");

    osc_rb_a:
        assert property ($past(bus.rd) && $past(bus.addr) == OSC_ARRAY_RB_OFS
            |-> rd_data == {4'h0, $past(ctrl.osc_array)}) else $error("osc readback wrong");

    // main scenarios reached
    cover property (ctrl.cal_begin);
    cover property (blk && $past(ana_in.up_req));
    cover property (opn && ctrl.loop_open);
endmodule

bind spt_regs spt_regs_chk spt_regs_chk_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .ana_in(ana_in),
    .ctrl(ctrl), .rd_data(rd_data));

// ==== bench/spt_regs_bench.sv ====
// self-checking bench for the synthesizer test register bank
`timescale 1ns/100ps
module spt_regs_bench;
    import spt_pkg::*;
    // ==========================================================
    // stimulus and observation
    logic sys_clk = 1'b0; // 100 MHz
    logic rst = 1'b1; // held for 12 cycles
    spt_bus_t bus = '0; // register port
    spt_analog_in_t ana_in = '0; // calibrated values, pulses
    spt_ctrl_t ctrl; // applied controls
    logic [7:0] rd_data; // read answer
    spt_ctrl_t snap; // controls seen 1 ns after the edge
    int n_fail = 0; // mismatches
    int cmp_count = 0; // comparisons
    localparam logic [7:0] DEF_A [9] = '{CAL_CTRL_OFS, SYNTH_RESET_OFS, DIVIDER_LOOP_OFS, PROBE_PUMP_OFS,
        PUMP_BLOCK_OSC_OFS, PUMP_SCALE_OFS, LOOP_OPEN_DAC_OFS, PUMP_LEVEL_RB_OFS, 8'h7F};
    localparam logic [7:0] DEF_E [9] = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h08, 8'h25, 8'h04, 8'h00, 8'h00};

    always #5 sys_clk = ~sys_clk;

    spt_regs spt_regs_i (.sys_clk(sys_clk), .rst(rst), .bus(bus), .ana_in(ana_in), .ctrl(ctrl),
        .rd_data(rd_data));

    // ==========================================================
    // shared tasks; every bus task starts and ends on a rising edge
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // write, then keep the controls of the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        snap = ctrl;
        @(posedge sys_clk);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        chk(n, e, rd_data);
        @(posedge sys_clk);
    endtask

    // let an analog input change reach the controls
    task automatic settle();
        @(posedge sys_clk);
        #1;
        snap = ctrl;
        @(posedge sys_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_defaults();
        settle();
        chk("divider selects", 8'h11, {snap.swing_onehot, snap.current_onehot});
        chk("control bits", 8'h09, {4'h0, snap.synth_reset_low, snap.resistor_bypass, snap.cap_detach,
            snap.probe_ground});
        chk("scale", 8'h25, {2'h0, snap.pump_scale_factor});
        foreach (DEF_A[i])
            rd(DEF_A[i], DEF_E[i], "reset value");
    endtask

    // every swing and current code, unused bits written as ones
    task automatic t_divider();
        for (int i = 0; i < 4; i++)
        begin
            wr(DIVIDER_LOOP_OFS, {i[1:0], 2'(3 - i), 4'hF});
            chk("swing", 8'(1 << i), {4'h0, snap.swing_onehot});
            chk("current", 8'(1 << (3 - i)), {4'h0, snap.current_onehot});
            chk("bypass detach", 8'h03, {6'h0, snap.resistor_bypass, snap.cap_detach});
            rd(DIVIDER_LOOP_OFS, {i[1:0], 2'(3 - i), 4'hC}, "divider");
        end
        wr(DIVIDER_LOOP_OFS, 8'h00);
        chk("bypass detach", 8'h00, {6'h0, snap.resistor_bypass, snap.cap_detach});
    endtask

    task automatic t_probe();
        for (int i = 0; i < 4; i++)
        begin
            wr(PROBE_PUMP_OFS, {i[1:0], 6'h10});
            chk("probe", {5'h0, i[1:0], i == 0}, {5'h0, snap.filter_probe_one, snap.filter_probe_two,
                snap.probe_ground});
        end
    endtask

    // forced values replace calibrated ones; the readback write equals the forced pump value, so refusal is not seen
    task automatic t_force();
        ana_in <= '{pump_level: 5'h0A, osc_array: 4'h3, cal_dac: 4'h9, up_req: 1'b0, dn_req: 1'b0};
        settle();
        rd(PUMP_LEVEL_RB_OFS, 8'h0A, "pump level");
        rd(TRIM_DAC_RB_OFS, 8'h09, "cal dac");
        rd(OSC_ARRAY_RB_OFS, 8'h03, "osc array");
        wr(PROBE_PUMP_OFS, 8'h3F);
        wr(PUMP_BLOCK_OSC_OFS, 8'h15);
        wr(LOOP_OPEN_DAC_OFS, 8'hFB);
        chk("loop open", 8'h01, {7'h0, snap.loop_open});
        wr(PUMP_LEVEL_RB_OFS, 8'hFF);
        rd(PUMP_LEVEL_RB_OFS, 8'h1F, "forced pump");
        rd(TRIM_DAC_RB_OFS, 8'h0B, "forced dac");
        rd(OSC_ARRAY_RB_OFS, 8'h05, "forced array");
        rd(LOOP_OPEN_DAC_OFS, 8'h1B, "loop reg");
        wr(LOOP_OPEN_DAC_OFS, 8'h04);
        rd(TRIM_DAC_RB_OFS, 8'h09, "closed dac");
        wr(PROBE_PUMP_OFS, 8'h10);
        wr(PUMP_BLOCK_OSC_OFS, 8'h08);
        rd(PUMP_LEVEL_RB_OFS, 8'h0A, "calibrated pump");
        rd(OSC_ARRAY_RB_OFS, 8'h03, "calibrated array");
    endtask

    task automatic t_block();
        {ana_in.up_req, ana_in.dn_req} <= 2'b11;
        settle();
        chk("pulses", 8'h03, {6'h0, snap.pump_up, snap.pump_dn});
        wr(PUMP_BLOCK_OSC_OFS, 8'h28);
        settle();
        chk("blocked", 8'h00, {6'h0, snap.pump_up, snap.pump_dn});
        wr(PUMP_BLOCK_OSC_OFS, 8'h08);
        {ana_in.up_req, ana_in.dn_req} <= 2'h0;
    endtask

    task automatic t_misc();
        wr(PUMP_SCALE_OFS, 8'hFF);
        chk("scale", 8'h3F, {2'h0, snap.pump_scale_factor});
        rd(PUMP_SCALE_OFS, 8'h3F, "scale reg");
        wr(CAL_CTRL_OFS, 8'h80);
        chk("cal kick", 8'h01, {7'h0, snap.cal_begin});
        settle();
        chk("cal kick end", 8'h00, {7'h0, snap.cal_begin});
        wr(CAL_CTRL_OFS, 8'hFF);
        chk("cal no rekick", 8'h00, {7'h0, snap.cal_begin});
        rd(CAL_CTRL_OFS, 8'h80, "cal reg");
        wr(SYNTH_RESET_OFS, 8'hFE);
        chk("synth reset", 8'h00, {7'h0, snap.synth_reset_low});
        rd(SYNTH_RESET_OFS, 8'h00, "synth reg");
        wr(SYNTH_RESET_OFS, 8'hFF);
        rd(SYNTH_RESET_OFS, 8'h01, "synth reg");
        wr(CAL_CTRL_OFS, 8'h00);
        chk("cal clear", 8'h00, {7'h0, snap.cal_begin});
        wr(CAL_CTRL_OFS, 8'h80);
        chk("cal rekick", 8'h01, {7'h0, snap.cal_begin});
        wr(CAL_CTRL_OFS, 8'h00);
        wr(PUMP_SCALE_OFS, 8'h25);
    endtask

    // ==========================================================
    // main sequence and hang guard
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_defaults();
        t_divider();
        t_probe();
        t_force();
        t_block();
        t_misc();
        finish_test();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
endmodule

// ==== core/spt_pkg.sv ====
// package of offsets, fields, reset values and carriers for the synthesizer test registers
package spt_pkg;

    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] CAL_CTRL_OFS = 8'h0E;
    localparam logic [7:0] SYNTH_RESET_OFS = 8'h13;
    localparam logic [7:0] DIVIDER_LOOP_OFS = 8'h1C;
    localparam logic [7:0] PROBE_PUMP_OFS = 8'h40;
    localparam logic [7:0] PUMP_BLOCK_OSC_OFS = 8'h41;
    localparam logic [7:0] PUMP_SCALE_OFS = 8'h42;
    localparam logic [7:0] LOOP_OPEN_DAC_OFS = 8'h43;
    localparam logic [7:0] PUMP_LEVEL_RB_OFS = 8'h44;
    localparam logic [7:0] TRIM_DAC_RB_OFS = 8'h45;
    localparam logic [7:0] OSC_ARRAY_RB_OFS = 8'h46;

    // ==========================================================
    // field positions
    localparam int CAL_START_BIT = 7;
    localparam int SYNTH_RESET_BIT = 0;
    localparam int SWING_LSB = 6;
    localparam int CURRENT_LSB = 4;
    localparam int BYPASS_BIT = 3;
    localparam int DETACH_BIT = 2;
    localparam int PROBE_ONE_BIT = 7;
    localparam int PROBE_TWO_BIT = 6;
    localparam int PUMP_FORCE_EN_BIT = 5;
    localparam int PUMP_FORCE_LSB = 0;
    localparam int PULSE_BLOCK_BIT = 5;
    localparam int OSC_FORCE_EN_BIT = 4;
    localparam int OSC_FORCE_LSB = 0;
    localparam int SCALE_LSB = 0;
    localparam int LOOP_OPEN_BIT = 4;
    localparam int DAC_FORCE_LSB = 0;

    // ==========================================================
    // reset values
    localparam logic SYNTH_RESET_RST = 1'h1;
    localparam logic [1:0] SWING_RST = 2'h0;
    localparam logic [1:0] CURRENT_RST = 2'h0;
    localparam logic [4:0] PUMP_FORCE_RST = 5'h10;
    localparam logic [3:0] OSC_FORCE_RST = 4'h8;
    localparam logic [5:0] SCALE_RST = 6'h25;
    localparam logic [3:0] DAC_FORCE_RST = 4'h4;

    // ==========================================================
    // divider swing and current codes
    typedef enum logic [1:0] {
        SWING_NOMINAL, SWING_TWO_THIRDS, SWING_SEVEN_THIRDS, SWING_FIVE_THIRDS
    } spt_swing_t;
    typedef enum logic [1:0] {
        CURRENT_NOMINAL, CURRENT_TWO_THIRDS, CURRENT_HALF, CURRENT_TWO_FIFTHS
    } spt_current_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr; // register byte address
        logic [7:0] wdata; // write data
        logic wr; // write strobe
        logic rd; // read strobe
    } spt_bus_t;

    typedef struct packed {
        logic [4:0] pump_level; // calibrated pump current
        logic [3:0] osc_array; // calibrated oscillator array
        logic [3:0] cal_dac; // calibration engine dac value
        logic up_req; // phase detector up pulse
        logic dn_req; // phase detector down pulse
    } spt_analog_in_t;

    typedef struct packed {
        logic synth_reset_low; // synthesizer reset, low active
        logic [3:0] swing_onehot; // one-hot of spt_swing_t
        logic [3:0] current_onehot; // one-hot of spt_current_t
        logic resistor_bypass; // loop resistor shorted
        logic cap_detach; // loop capacitor removed
        logic filter_probe_one; // test point one to probe pin
        logic filter_probe_two; // test point two to probe pin
        logic probe_ground; // probe pin grounded
        logic pump_up; // gated up pulse
        logic pump_dn; // gated down pulse
        logic [4:0] pump_level; // applied pump current
        logic [3:0] osc_array; // applied oscillator array
        logic [5:0] pump_scale_factor; // pump scaling factor
        logic loop_open; // synthesizer loop broken
        logic [3:0] cal_dac; // applied calibration dac
        logic cal_begin; // one-cycle calibration kick
    } spt_ctrl_t;

endpackage

// ==== core/spt_regs.sv ====
// synthesizer configuration, override and readback register bank
`timescale 1ns/100ps
// ==========================================================
module spt_regs
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire spt_pkg::spt_bus_t bus,
    input wire spt_pkg::spt_analog_in_t ana_in,
    output spt_pkg::spt_ctrl_t ctrl,
    output logic [spt_pkg::DATA_W-1:0] rd_data
);
    import spt_pkg::*;

    // ==========================================================
    // register map, byte offsets on the plain port
    // 0Eh calibration control, start bit seven only
    // 13h synthesizer reset, bit zero, low active
    // 1Ch divider swing and current, resistor bypass, cap detach
    // 40h probe selects, pump force enable, forced pump current
    // 41h pulse block, array force enable, forced array value
    // 42h pump scale factor, six bits
    // 43h loop open and forced calibration dac
    // 44h applied pump current, read only
    // 45h applied calibration dac, read only
    // 46h applied oscillator array, read only
    // every other offset reads zero and drops writes

    // ==========================================================
    // notes for software
    // override registers are test aids; leave them at reset values
    // in normal use, or the loop runs on uncalibrated settings
    // detach and a full-scale pump factor only suit the fastest rates
    // a second calibration needs the start bit written to zero first,
    // since a repeated one is taken as no edge at all
    // readbacks show the registered outputs, one cycle behind the
    // calibrated inputs they follow

    // ==========================================================
    // state record
    // stored fields first, then the registered outputs built from them
    typedef struct packed {
        logic cal_start; // calibration start bit as written
        logic synth_reset_low; // synthesizer reset bit
        logic [1:0] swing; // divider swing code
        logic [1:0] current; // divider current code
        logic bypass; // resistor bypass bit
        logic detach; // capacitor detach bit
        logic probe_one; // test point one select
        logic probe_two; // test point two select
        logic pump_force_en; // pump force enable
        logic [4:0] pump_force; // forced pump current
        logic pulse_block; // pump pulse suppression
        logic osc_force_en; // array force enable
        logic [3:0] osc_force; // forced array value
        logic [5:0] scale; // pump scale factor
        logic loop_open; // loop break bit
        logic [3:0] dac_force; // forced calibration dac
        spt_ctrl_t out; // registered outputs
        logic [DATA_W-1:0] rdata; // registered read answer
    } spt_state_t;

    // ==========================================================
    // reset image, built from the package reset values
    // outputs start at their control defaults; pump level, array and dac sit at zero until the calibrated inputs are first sampled
    localparam spt_state_t RST_STATE = '{
        cal_start: 1'h0,
        synth_reset_low: SYNTH_RESET_RST,
        swing: SWING_RST,
        current: CURRENT_RST,
        bypass: 1'h0,
        detach: 1'h0,
        probe_one: 1'h0,
        probe_two: 1'h0,
        pump_force_en: 1'h0,
        pump_force: PUMP_FORCE_RST,
        pulse_block: 1'h0,
        osc_force_en: 1'h0,
        osc_force: OSC_FORCE_RST,
        scale: SCALE_RST,
        loop_open: 1'h0,
        dac_force: DAC_FORCE_RST,
        out: '{
            synth_reset_low: SYNTH_RESET_RST,
            swing_onehot: 4'h1,
            current_onehot: 4'h1,
            resistor_bypass: 1'h0,
            cap_detach: 1'h0,
            filter_probe_one: 1'h0,
            filter_probe_two: 1'h0,
            probe_ground: 1'h1,
            pump_up: 1'h0,
            pump_dn: 1'h0,
            pump_level: 5'h00,
            osc_array: 4'h0,
            pump_scale_factor: SCALE_RST,
            loop_open: 1'h0,
            cal_dac: 4'h0,
            cal_begin: 1'h0
        },
        rdata: 8'h00
    };

    // ==========================================================
    // helpers
    // small decoders used more than once

    // two-bit code to one-hot select, shared by swing and current
    function automatic logic [3:0] code_onehot(input logic [1:0] code);
        logic [3:0] sel;
        sel = 4'h0;
        // any two-bit code sets exactly one select line
        sel[code] = 1'h1;
        return sel;
    endfunction

    // address match on a strobe
    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
        // a strobe with a foreign address is not ours
        return strobe && (a == ofs);
    endfunction

    spt_state_t st; // current state
    spt_state_t next_st; // next state

    // ==========================================================
    // register writes

    // write side, then derived outputs from the next register image
    always_comb
    begin
        // hold every stored field unless a write names it
        next_st = st;

        // calibration control; only the start bit is kept here
        if (hit(bus.wr, bus.addr, CAL_CTRL_OFS))
        begin
            next_st.cal_start = bus.wdata[CAL_START_BIT];
        end

        // synthesizer reset, bits above bit zero are dropped
        if (hit(bus.wr, bus.addr, SYNTH_RESET_OFS))
        begin
            next_st.synth_reset_low = bus.wdata[SYNTH_RESET_BIT];
        end

        // divider and loop filter controls
        if (hit(bus.wr, bus.addr, DIVIDER_LOOP_OFS))
        begin
            next_st.swing = bus.wdata[SWING_LSB +: 2];
            next_st.current = bus.wdata[CURRENT_LSB +: 2];
            next_st.bypass = bus.wdata[BYPASS_BIT];
            next_st.detach = bus.wdata[DETACH_BIT];
        end

        // probe routing and pump force
        if (hit(bus.wr, bus.addr, PROBE_PUMP_OFS))
        begin
            next_st.probe_one = bus.wdata[PROBE_ONE_BIT];
            next_st.probe_two = bus.wdata[PROBE_TWO_BIT];
            next_st.pump_force_en = bus.wdata[PUMP_FORCE_EN_BIT];
            next_st.pump_force = bus.wdata[PUMP_FORCE_LSB +: 5];
        end

        // pulse block and array force; top two bits unused
        if (hit(bus.wr, bus.addr, PUMP_BLOCK_OSC_OFS))
        begin
            next_st.pulse_block = bus.wdata[PULSE_BLOCK_BIT];
            next_st.osc_force_en = bus.wdata[OSC_FORCE_EN_BIT];
            next_st.osc_force = bus.wdata[OSC_FORCE_LSB +: 4];
        end

        // pump scale factor; 3Fh suits the two fastest baud rates
        if (hit(bus.wr, bus.addr, PUMP_SCALE_OFS))
        begin
            next_st.scale = bus.wdata[SCALE_LSB +: 6];
        end

        // loop break and forced dac
        if (hit(bus.wr, bus.addr, LOOP_OPEN_DAC_OFS))
        begin
            next_st.loop_open = bus.wdata[LOOP_OPEN_BIT];
            next_st.dac_force = bus.wdata[DAC_FORCE_LSB +: 4];
        end
        // writes to the three readback offsets fall through untouched

        // ======================================================
        // outputs toward the synthesizer, registered

        // reset line follows the bit
        next_st.out.synth_reset_low = next_st.synth_reset_low;

        // divider swing and current selects
        next_st.out.swing_onehot = code_onehot(next_st.swing);
        next_st.out.current_onehot = code_onehot(next_st.current);

        // loop filter reshaping
        next_st.out.resistor_bypass = next_st.bypass;
        next_st.out.cap_detach = next_st.detach;

        // probe pin: each set bit routes its point, none set grounds it
        next_st.out.filter_probe_one = next_st.probe_one;
        next_st.out.filter_probe_two = next_st.probe_two;
        next_st.out.probe_ground = !(next_st.probe_one || next_st.probe_two);

        // pump current: forced value or the calibrated one
        // the forced value also feeds the readback, as applied
        if (next_st.pump_force_en)
        begin
            next_st.out.pump_level = next_st.pump_force;
        end
        else
        begin
            next_st.out.pump_level = ana_in.pump_level;
        end

        // pump pulses pass only while not blocked
        // the gate costs one cycle of delay; the loop filter averages
        // many pulses, so a registered pulse is the cleaner trade
        next_st.out.pump_up = ana_in.up_req && !next_st.pulse_block;
        next_st.out.pump_dn = ana_in.dn_req && !next_st.pulse_block;

        // oscillator array: forced value or the calibrated one
        if (next_st.osc_force_en)
        begin
            next_st.out.osc_array = next_st.osc_force;
        end
        else
        begin
            next_st.out.osc_array = ana_in.osc_array;
        end

        // scaling factor straight through
        next_st.out.pump_scale_factor = next_st.scale;

        // forced dac only counts with the loop open
        // a closed loop always keeps the calibration engine in charge
        next_st.out.loop_open = next_st.loop_open;
        if (next_st.loop_open)
        begin
            next_st.out.cal_dac = next_st.dac_force;
        end
        else
        begin
            next_st.out.cal_dac = ana_in.cal_dac;
        end

        // kick on a zero-to-one write only; a repeated one does nothing,
        // so software must clear the bit before the next calibration
        next_st.out.cal_begin = next_st.cal_start && !st.cal_start;

        // ======================================================
        // read side, answered in the following cycle only
        // clearing first keeps the answer to one cycle and unused bits at zero
        next_st.rdata = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                // only the start bit is kept, the rest reads zero
                CAL_CTRL_OFS:
                begin
                    next_st.rdata[CAL_START_BIT] = st.cal_start;
                end

                // reset bit in bit zero
                SYNTH_RESET_OFS:
                begin
                    next_st.rdata[SYNTH_RESET_BIT] = st.synth_reset_low;
                end

                // divider and loop filter bits, low two bits zero
                DIVIDER_LOOP_OFS:
                begin
                    next_st.rdata[SWING_LSB +: 2] = st.swing;
                    next_st.rdata[CURRENT_LSB +: 2] = st.current;
                    next_st.rdata[BYPASS_BIT] = st.bypass;
                    next_st.rdata[DETACH_BIT] = st.detach;
                end

                // probe selects and pump force
                PROBE_PUMP_OFS:
                begin
                    next_st.rdata[PROBE_ONE_BIT] = st.probe_one;
                    next_st.rdata[PROBE_TWO_BIT] = st.probe_two;
                    next_st.rdata[PUMP_FORCE_EN_BIT] = st.pump_force_en;
                    next_st.rdata[PUMP_FORCE_LSB +: 5] = st.pump_force;
                end

                // pulse block and array force, top two bits zero
                PUMP_BLOCK_OSC_OFS:
                begin
                    next_st.rdata[PULSE_BLOCK_BIT] = st.pulse_block;
                    next_st.rdata[OSC_FORCE_EN_BIT] = st.osc_force_en;
                    next_st.rdata[OSC_FORCE_LSB +: 4] = st.osc_force;
                end

                // six-bit pump factor
                PUMP_SCALE_OFS:
                begin
                    next_st.rdata[SCALE_LSB +: 6] = st.scale;
                end

                // loop break and forced dac
                LOOP_OPEN_DAC_OFS:
                begin
                    next_st.rdata[LOOP_OPEN_BIT] = st.loop_open;
                    next_st.rdata[DAC_FORCE_LSB +: 4] = st.dac_force;
                end

                // readbacks show what the synthesizer gets right now
                PUMP_LEVEL_RB_OFS:
                begin
                    next_st.rdata[4:0] = st.out.pump_level;
                end

                // applied calibration dac
                TRIM_DAC_RB_OFS:
                begin
                    next_st.rdata[3:0] = st.out.cal_dac;
                end

                // applied oscillator array
                OSC_ARRAY_RB_OFS:
                begin
                    next_st.rdata[3:0] = st.out.osc_array;
                end

                // unmapped offsets answer zero
                default:
                begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // state register, synchronous reset
    // one image for the whole record, so no field can miss its default
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st <= RST_STATE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs come straight from the state register
    // nothing combinational reaches a port, so pin timing is one flop
    assign ctrl = st.out;
    assign rd_data = st.rdata;

endmodule
